/* File: bench/phy_mgmt_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // host side
  input wire logic        mem_sel,
  input wire logic [15:0] mem_addr,
  input wire logic        io_sel,
  input wire logic [15:0] io_addr,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  // pins
  input wire logic        mdc,
  input wire logic        mdio_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire sel    = mem_sel | io_sel;
  wire mem_in = mem_addr[15:13] == 3'h1;
  wire io_in  = io_addr[15:13] == 3'h1;
  wire win_sel = mem_sel ? mem_in : (io_sel && io_in);
  reg  seen_q;
  always @(posedge clk) begin
    if (!resetn) seen_q <= 1'b0;
    else if (mdio_oe) seen_q <= 1'b1;
  end
  ack_after_sel_a: assert property (sel |=> ack) else $error("no ack after select");
  no_stray_ack_a: assert property (!sel |=> !ack) else $error("ack without select");
  rsvd_zero_a: assert property (ack |-> rdata[29:16] == 14'h0)
    else $error("reserved bits not zero");
  outside_zero_a: assert property (mem_sel && !mem_in |=> rdata == 32'h0)
    else $error("outside window not zero");
  busy_shown_a: assert property (win_sel && mdio_oe |=> rdata[30])
    else $error("busy not shown");
  valid_shown_a: assert property (win_sel && mdio_oe |=> !rdata[31])
    else $error("valid shown during frame");
  io_path_a: assert property (io_sel && !mem_sel && io_in && mdio_oe |=> rdata[30])
    else $error("io path status wrong");
  frame_cause_a: assert property ($rose(mdio_oe) |-> $past(ack))
    else $error("frame without access");
  data_idle_a: assert property (ack && !seen_q |-> rdata[15:0] == 16'h0)
    else $error("data changed without frame");
  mdc_quiet_a: assert property (!seen_q && !mdio_oe |-> !mdc)
    else $error("mdc runs while ignored");
  cover property (mem_sel && mem_in);
  cover property (io_sel && io_in);
  cover property (mem_sel && !mem_in);
  cover property (win_sel && mdio_oe);
endmodule
bind phy_mgmt_register_access_port phy_mgmt_checker i_phy_mgmt_checker (.clk(clk),
  .resetn(resetn), .mem_sel(mem_sel), .mem_addr(mem_addr), .io_sel(io_sel),
  .io_addr(io_addr), .rdata(rdata), .ack(ack), .mdc(mdc), .mdio_oe(mdio_oe));
`default_nettype wire

/* File: bench/phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_model #(
  parameter logic [15:0] READ_VAL = 16'h5A3C
) (
  // management pins
  input  wire logic        mdc,
  input  wire logic        mdio_o,
  input  wire logic        mdio_oe,
  output wire logic        mdio_i,
  // observation
  output int               mdc_edges,
  output var  logic [13:0] hdr,
  output var  logic [15:0] wdat
);
  logic [6:0]  n = 7'h00;
  logic        rd = 1'b0;
  logic        drv = 1'b0;
  logic [15:0] sh = 16'h0000;
  // line has a pull-up, so a released line reads one
  assign mdio_i = mdio_oe ? mdio_o : (drv ? sh[15] : 1'b1);
  initial begin
    mdc_edges = 0;
    hdr = 14'h0000;
    wdat = 16'h0000;
  end
  // rises counted from frame start: 32 preamble, 14 header, 2 turnaround, 16 data
  always @(posedge mdio_oe) n <= 7'h00;
  always @(posedge mdc) begin
    mdc_edges <= mdc_edges + 1;
    n <= n + 7'h01;
    if (n >= 7'd32 && n <= 7'd45) hdr <= {hdr[12:0], mdio_i};
    if (n == 7'd34) rd <= mdio_i;
    if (n >= 7'd48 && n <= 7'd63 && !rd) wdat <= {wdat[14:0], mdio_i};
    // read data goes out after each rise, the station takes it at the next rise
    if (n == 7'd47 && rd) begin
      sh <= READ_VAL;
      drv <= 1'b1;
    end else if (n >= 7'd48 && n <= 7'd62) begin
      sh <= {sh[14:0], 1'b0};
    end
    if (n == 7'd63) drv <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, resetn = 0, mem_sel = 0, mem_wr = 0, io_sel = 0, io_wr = 0;
  logic [15:0] mem_addr = 16'h0, io_addr = 16'h0;
  logic [31:0] mem_wdata = 32'h0, io_wdata = 32'h0;
  wire  [31:0] rdata;
  wire         ack, mdc, mdio_o, mdio_oe, mdio_i;
  int          errors = 0, n_tests = 0, cyc = 0, oe_cnt = 0, mdc_edges;
  logic [13:0] hdr;
  logic [15:0] wdat;
  localparam logic [15:0] READ_VAL = 16'h5A3C;
  phy_mgmt_register_access_port #(.MDC_HALF(2)) i_phy_mgmt_register_access_port (
    .clk(clk), .resetn(resetn), .mem_sel(mem_sel), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .io_sel(io_sel), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .rdata(rdata), .ack(ack), .mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_i(mdio_i));
  phy_model #(.READ_VAL(READ_VAL)) i_phy_model (.mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_i(mdio_i), .mdc_edges(mdc_edges), .hdr(hdr), .wdat(wdat));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mdio_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task acc(bit io, bit wr, logic [15:0] a, logic [31:0] exp);
    @(posedge clk);
    if (io) begin
      io_sel <= 1; io_wr <= wr; io_addr <= a; io_wdata <= 32'h0000A5A5;
    end else begin
      mem_sel <= 1; mem_wr <= wr; mem_addr <= a; mem_wdata <= 32'h0000A5A5;
    end
    @(posedge clk);
    mem_sel <= 0;
    io_sel <= 0;
    #1;
    chk("ack", 32'h1, {31'h0, ack});
    chk("rdata", exp, rdata);
  endtask
  task t_reset;
    chk("reset rdata", 32'h0, rdata);
    chk("reset pins", 32'h0, {29'h0, ack, mdc, mdio_oe});
    $display("test reset done");
  endtask
  task t_outside;
    acc(0, 0, 16'h1FFC, 32'h0);
    acc(0, 0, 16'h4000, 32'h0);
    acc(1, 0, 16'h4008, 32'h0);
    repeat (20) @(posedge clk);
    #1;
    chk("frames outside", 32'h0, oe_cnt);
    $display("test outside reads done");
  endtask
  task t_write;
    acc(0, 1, 16'h2084, 32'h80000000);
    acc(1, 1, 16'h3004, 32'h4000A5A5);
    acc(0, 0, 16'h3FFC, 32'h4000A5A5);
    repeat (300) @(posedge clk);
    #1;
    chk("write header", {18'h0, 14'h1421}, hdr);
    chk("write data", 32'h0000A5A5, wdat);
    chk("mdc edges", 32'd64, mdc_edges);
    $display("test write frame done");
  endtask
  task t_read;
    acc(1, 0, 16'h2F84, 32'h0000A5A5);
    repeat (300) @(posedge clk);
    #1;
    chk("read header", {18'h0, 14'h1BE1}, hdr);
    chk("mdc edges", 32'd128, mdc_edges);
    acc(0, 0, 16'h2000, {16'h8000, READ_VAL});
    repeat (300) @(posedge clk);
    #1;
    chk("last mdc edges", 32'd192, mdc_edges);
    $display("test read frame done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    #1;
    t_reset();
    t_outside();
    t_write();
    t_read();
    test_done();
  end
endmodule
`default_nettype wire

/* File: src/mdio_shifter.v */
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_map.vh"

// one clause 22 frame on mdc/mdio; mdc is made here by division of clk
module mdio_shifter #(
  parameter HALF_DIV = `MDC_HALF_DIV
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // request
  input  wire        start,
  input  wire        is_read,
  input  wire [4:0]  phy_addr,
  input  wire [4:0]  reg_addr,
  input  wire [15:0] wr_data,
  // answer
  output reg         done,
  output reg  [15:0] rd_data,
  // pins
  output reg         mdc,
  output reg         mdio_o,
  output reg         mdio_oe,
  input  wire        mdio_i
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PRE  = 3'h1;
  localparam ST_HDR  = 3'h2;
  localparam ST_TA   = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_END  = 3'h5;

  reg [2:0]  st_q;
  reg [7:0]  div_q;
  reg [5:0]  cnt_q;
  reg [13:0] hdr_q;
  reg [15:0] dat_q;
  reg        rd_q;
  reg        mdi_s1_q;
  reg        mdi_s2_q;

  localparam [7:0] HALF_M1 = HALF_DIV - 1;
  localparam [1:0] TA_WR   = `MF_TA_WRITE;

  wire tick      = (div_q == HALF_M1);
  wire fall_edge = tick && mdc;
  wire rise_edge = tick && !mdc;

  always @(posedge clk) begin
    mdi_s1_q <= mdio_i;
    mdi_s2_q <= mdi_s1_q;
    if (!resetn) begin
      st_q    <= ST_IDLE;
      div_q   <= 8'h00;
      cnt_q   <= 6'h00;
      hdr_q   <= 14'h0000;
      dat_q   <= 16'h0000;
      rd_q    <= 1'b0;
      mdc     <= 1'b0;
      mdio_o  <= 1'b0;
      mdio_oe <= 1'b0;
      done    <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      done  <= 1'b0;
      div_q <= (st_q == ST_IDLE || tick) ? 8'h00 : div_q + 8'h01;
      if (st_q != ST_IDLE && tick)
        mdc <= !mdc;
      case (st_q)
        ST_IDLE: begin
          mdc     <= 1'b0;
          mdio_oe <= 1'b0;
          if (start) begin
            rd_q    <= is_read;
            hdr_q   <= {`MF_START, is_read ? `MF_OP_READ : `MF_OP_WRITE, phy_addr, reg_addr};
            dat_q   <= wr_data;
            cnt_q   <= `MF_PREAMBLE_LEN;
            mdio_o  <= 1'b1;
            mdio_oe <= 1'b1;
            st_q    <= ST_PRE;
          end
        end
        ST_PRE: if (fall_edge) begin
          if (cnt_q == 6'h01) begin
            cnt_q  <= `MF_HDR_LEN;
            mdio_o <= hdr_q[13];
            hdr_q  <= {hdr_q[12:0], 1'b0};
            st_q   <= ST_HDR;
          end else
            cnt_q <= cnt_q - 6'h01;
        end
        ST_HDR: if (fall_edge) begin
          if (cnt_q == 6'h01) begin
            cnt_q   <= `MF_TA_LEN;
            mdio_o  <= TA_WR[1];
            mdio_oe <= !rd_q;
            st_q    <= ST_TA;
          end else begin
            cnt_q  <= cnt_q - 6'h01;
            mdio_o <= hdr_q[13];
            hdr_q  <= {hdr_q[12:0], 1'b0};
          end
        end
        ST_TA: if (fall_edge) begin
          if (cnt_q == 6'h01) begin
            cnt_q  <= `MF_DATA_LEN;
            mdio_o <= dat_q[15];
            dat_q  <= {dat_q[14:0], 1'b0};
            st_q   <= ST_DATA;
          end else begin
            cnt_q  <= cnt_q - 6'h01;
            mdio_o <= 1'b0;
          end
        end
        ST_DATA: begin
          // phy drives on rising edge; take the bit just before our rising edge
          if (rise_edge && rd_q)
            dat_q[0] <= mdi_s2_q;
          if (fall_edge) begin
            if (cnt_q == 6'h01) begin
              mdio_oe <= 1'b0;
              st_q    <= ST_END;
            end else begin
              cnt_q  <= cnt_q - 6'h01;
              mdio_o <= dat_q[15];
              dat_q  <= {dat_q[14:0], 1'b0};
            end
          end
        end
        ST_END: begin
          done    <= 1'b1;
          rd_data <= rd_q ? dat_q : rd_data;
          st_q    <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: src/phy_mgmt_map.vh */
`ifndef PHY_MGMT_MAP_VH
`define PHY_MGMT_MAP_VH

// access window, byte addresses 0x2000..0x3FFF
`define WIN_BASE        16'h2000
`define WIN_BASE_HI     3'h1
`define WIN_ADDR_W      16
// window word layout
`define WIN_VALID_BIT   31
`define WIN_BUSY_BIT    30
`define WIN_RSVD_HI     29
`define WIN_RSVD_LO     16
`define WIN_DATA_HI     15
`define WIN_DATA_LO     0
// offset decode
`define PHY_ADDR_HI     11
`define PHY_ADDR_LO     7
`define REG_ADDR_HI     6
`define REG_ADDR_LO     2
// reset values
`define RST_VALID       1'h1
`define RST_BUSY        1'h1
// management frame fields
`define MF_PREAMBLE_LEN 6'h20
`define MF_START        2'h1
`define MF_OP_READ      2'h2
`define MF_OP_WRITE     2'h1
`define MF_TA_WRITE     2'h2
`define MF_HDR_LEN      6'h0E
`define MF_TA_LEN       6'h02
`define MF_DATA_LEN     6'h10
// mdc divider: half period in clk cycles
`define MDC_HALF_DIV    8'h0A

`endif

/* File: src/phy_mgmt_register_access_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_map.vh"

module phy_mgmt_register_access_port #(
  parameter MDC_HALF = `MDC_HALF_DIV
) (
  // clock and reset (ethernet transmit clock)
  input  wire        clk,
  input  wire        resetn,
  // memory-space register port
  input  wire        mem_sel,
  input  wire        mem_wr,
  input  wire [15:0] mem_addr,
  input  wire [31:0] mem_wdata,
  // indirect i/o register port
  input  wire        io_sel,
  input  wire        io_wr,
  input  wire [15:0] io_addr,
  input  wire [31:0] io_wdata,
  // read answer, shared by both paths
  output reg  [31:0] rdata,
  output reg         ack,
  // management pins
  output wire        mdc,
  output wire        mdio_o,
  output wire        mdio_oe,
  input  wire        mdio_i
);
  reg         busy_q;
  reg         valid_q;
  reg  [15:0] data_q;
  reg         start_q;
  reg         is_read_q;
  reg  [4:0]  phy_q;
  reg  [4:0]  reg_q;
  reg  [15:0] wr_q;
  // busy reads one in reset; the serial side is idle then, so it drops on the first edge after
  reg         init_q;

  wire        done;
  wire [15:0] rd_data;

  // memory path wins when both hit in one cycle; the other is dropped as
  // software must serialise its accesses anyway
  wire        sel   = mem_sel | io_sel;
  wire        wr    = mem_sel ? mem_wr : io_wr;
  wire [15:0] addr  = mem_sel ? mem_addr : io_addr;
  wire [31:0] wdata = mem_sel ? mem_wdata : io_wdata;
  wire        hit   = sel && (addr[15:13] == `WIN_BASE_HI);

  wire [31:0] window_word = {valid_q, busy_q, 14'h0000, data_q};

  always @(posedge clk) begin
    if (!resetn) begin
      busy_q    <= `RST_BUSY;
      valid_q   <= `RST_VALID;
      data_q    <= 16'h0000;
      start_q   <= 1'b0;
      is_read_q <= 1'b0;
      phy_q     <= 5'h00;
      reg_q     <= 5'h00;
      wr_q      <= 16'h0000;
      rdata     <= 32'h0000_0000;
      ack       <= 1'b0;
    end else begin
      start_q <= 1'b0;
      ack     <= sel;
      rdata   <= hit ? window_word : 32'h0000_0000;
      if (done) begin
        busy_q  <= 1'b0;
        valid_q <= is_read_q;
        if (is_read_q)
          data_q <= rd_data;
      end else if (init_q) begin
        busy_q <= 1'b0;
      end else if (hit && !busy_q && !start_q) begin
        busy_q    <= 1'b1;
        valid_q   <= 1'b0;
        start_q   <= 1'b1;
        is_read_q <= !wr;
        phy_q     <= addr[`PHY_ADDR_HI:`PHY_ADDR_LO];
        reg_q     <= addr[`REG_ADDR_HI:`REG_ADDR_LO];
        wr_q      <= wdata[`WIN_DATA_HI:`WIN_DATA_LO];
        if (wr)
          data_q <= wdata[`WIN_DATA_HI:`WIN_DATA_LO];
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn)
      init_q <= 1'b1;
    else
      init_q <= 1'b0;
  end

  mdio_shifter #(
    .HALF_DIV (MDC_HALF)
  ) u_shift (
    .clk      (clk),
    .resetn   (resetn & ~init_q),
    .start    (start_q),
    .is_read  (is_read_q),
    .phy_addr (phy_q),
    .reg_addr (reg_q),
    .wr_data  (wr_q),
    .done     (done),
    .rd_data  (rd_data),
    .mdc      (mdc),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .mdio_i   (mdio_i)
  );
endmodule
`default_nettype wire
